// ### design/adc_output_test_pattern_gen.sv
// converter output test pattern generator with downconverter and link test routing
`timescale 1ns/1ps
`include "tpg_consts.svh"

// Notes on behaviour
// R1: 4-bit test-mode code; 0 normal, 1 midscale, 2 positive, 3 negative full scale.
// R2: any test mode swaps converter samples for generated pattern through formatting.
// R3: checker, pn, toggle, user patterns bypass formatting; others are formatted.
// R4: writing bit 4 or 5 of test-mode register reseeds both pn generators.
// R5: analog input ignored in test mode; encode clock must be running.
// R6: code 0100 alternates 0x1555 and 0x2AAA each sample.
// R7: code 0101 long pn x^23+x^18+1 seeded 0x3AFF.
// R8: code 0110 short pn x^9+x^5+1 seeded 0x0092.
// R9: code 0111 alternates 0x0000 and 0x3FFF each sample.
// R10: code 1000 plays user patterns 1..4 bits 15:2, repeating.
// R11: single user mode plays four patterns once then zeros.
// R12: code 1111 ramps up by one, wrapping at 2^14.
// R13: software enables patterns per downconverter via control bits 2 and 0.
// R14: downconverter i takes channel a pattern, q takes channel b pattern.
// R15: fourth downconverter: i from channel a with bit 0, q never patterned.
// R16: link test modes set by two registers, injected at selectable points.
// R17: leaving a nonzero link test mode needs a soft reset; the code leaves it on any write to 0x573.
// R18: writing 0x81 to address zero soft resets; bits clear themselves.
// R19: transport sample test, bit 5, sends raw converter samples.
// R20: inject field 00 sample input, 01 10-bit phy, 10 scrambler input.
// R21: one new pattern word per encode clock per channel.
module adc_output_test_pattern_gen #(
    parameter int NUM_DDC = 4,
    parameter int SAMPLE_W = 14
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_reset,
    // serial-port register access
    input  wire tpg_pkg::reg_req_s    i_req,
    output logic [7:0]                o_rdata,
    // converter samples, two channels
    input  wire tpg_pkg::sample_s     i_adc_a,
    input  wire tpg_pkg::sample_s     i_adc_b,
    input  wire logic                 i_twos_comp,
    // downconverter datapath samples
    input  wire tpg_pkg::iq_s         i_ddc [NUM_DDC],
    input  wire logic                 i_ddc_mode,
    // outputs to the link
    output tpg_pkg::sample_s          o_fmt_a,
    output tpg_pkg::sample_s          o_fmt_b,
    output tpg_pkg::iq_s              o_ddc [NUM_DDC],
    output logic                      o_test_active,
    output logic [3:0]                o_link_test_mode,
    output tpg_pkg::inject_point_e    o_link_inject,
    output logic                      o_link_sample_test,
    output logic                      o_soft_reset
);
    import tpg_pkg::*;

    initial begin
        if (NUM_DDC != 4 || SAMPLE_W != 14) begin
            $error("unsupported parameters");
        end
    end

    // ----------------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------------
    logic [7:0] ctm_a;
    logic [7:0] ctm_b;
    logic [7:0] ddc_ctrl [4];
    logic [7:0] user_reg [8];
    logic [7:0] link_sample;
    logic [7:0] link_mode;
    logic [7:0] link_mode_ext;
    logic       ctm_wr;
    logic       soft_reset;

    tpg_reg_file u_regs (
        .i_sys_clk       (i_sys_clk),
        .i_reset         (i_reset),
        .i_req           (i_req),
        .o_rdata         (o_rdata),
        .o_soft_reset    (soft_reset),
        .o_ctm_a         (ctm_a),
        .o_ctm_b         (ctm_b),
        .o_ddc_ctrl      (ddc_ctrl),
        .o_user          (user_reg),
        .o_link_sample   (link_sample),
        .o_link_mode     (link_mode),
        .o_link_mode_ext (link_mode_ext),
        .o_ctm_wr        (ctm_wr)
    );

    assign o_soft_reset = soft_reset; // see R18

    // ----------------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------------
    test_mode_e mode_a;
    test_mode_e mode_b;
    logic       pn_reseed;
    logic       user_single;
    logic       core_rst;

    assign mode_a      = test_mode_e'(ctm_a[3:0]); // see R1
    assign mode_b      = test_mode_e'(ctm_b[3:0]);
    assign user_single = ctm_a[`CTM_USER_SINGLE_BIT];
    assign core_rst    = i_reset || soft_reset;
    // reseed when either reset bit is written
    assign pn_reseed   = ctm_wr && (ctm_a[`CTM_PN_RESET_LO_BIT] || ctm_a[`CTM_PN_RESET_HI_BIT]); // see R4

    // true for codes that skip output formatting
    function automatic logic bypasses_format(input test_mode_e m);
        case (m)
            TM_CHECKER, TM_PN_LONG, TM_PN_SHORT, TM_TOGGLE, TM_USER: bypasses_format = 1'b1;
            default:                                                 bypasses_format = 1'b0;
        endcase
    endfunction

    // output formatting: offset binary flips the sign bit
    function automatic logic [13:0] format_word(input logic [13:0] w, input logic twos);
        format_word = twos ? w : {~w[13], w[12:0]};
    endfunction

    // ----------------------------------------------------------------------
    // pattern sources
    // ----------------------------------------------------------------------
    logic [13:0] pn_long;
    logic [13:0] pn_short;
    logic        phase;
    logic [13:0] ramp;
    logic [2:0]  user_idx;
    logic        user_done;

    tpg_pn_gen #(.DEG(23), .TAP(18), .SEED(`PN23_SEED), .WIDTH(14)) u_pn_long ( // see R7
        .i_sys_clk (i_sys_clk),
        .i_reset   (core_rst),
        .i_reseed  (pn_reseed),
        .i_advance (1'b1),
        .o_word    (pn_long)
    );

    tpg_pn_gen #(.DEG(9), .TAP(5), .SEED({14'h0000, `PN9_SEED}), .WIDTH(14)) u_pn_short ( // see R8
        .i_sys_clk (i_sys_clk),
        .i_reset   (core_rst),
        .i_reseed  (pn_reseed),
        .i_advance (1'b1),
        .o_word    (pn_short)
    );

    // alternating phase shared by checkerboard and toggle
    always_ff @(posedge i_sys_clk) begin
        if (core_rst || ctm_wr) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase; // see R6 see R9
        end
    end

    // ramp counter wrapping at 2^14
    always_ff @(posedge i_sys_clk) begin
        if (core_rst || ctm_wr) begin
            ramp <= 14'h0000;
        end else begin
            ramp <= ramp + 14'h0001; // see R12
        end
    end

    // user pattern sequencer
    always_ff @(posedge i_sys_clk) begin
        if (core_rst || ctm_wr) begin
            user_idx  <= 3'h0;
            user_done <= 1'b0;
        end else if (!user_done) begin
            user_idx <= user_idx + 3'h1;
            if (user_idx == 3'h3) begin
                user_idx  <= 3'h0;                // see R10
                user_done <= user_single;         // see R11
            end
        end
    end

    // select the pattern word for one channel
    function automatic logic [13:0] pattern(input test_mode_e m, input logic [13:0] raw,
                                            input logic [13:0] pl, input logic [13:0] ps,
                                            input logic ph, input logic [13:0] rp,
                                            input logic [15:0] up, input logic done);
        case (m)
            TM_NORMAL:   pattern = raw;
            TM_MIDSCALE: pattern = `PAT_MIDSCALE;                    // see R1
            TM_POS_FULL: pattern = `PAT_POS_FULL;                    // see R1
            TM_NEG_FULL: pattern = `PAT_NEG_FULL;                    // see R1
            TM_CHECKER:  pattern = ph ? `PAT_CHECKER_B : `PAT_CHECKER_A; // see R6
            TM_PN_LONG:  pattern = pl;                               // see R7
            TM_PN_SHORT: pattern = ps;                               // see R8
            TM_TOGGLE:   pattern = ph ? `PAT_ONES : `PAT_ZERO;       // see R9
            TM_USER:     pattern = done ? `PAT_ZERO : up[15:2];      // see R10 see R11
            TM_RAMP:     pattern = rp;                               // see R12
            default:     pattern = raw;
        endcase
    endfunction

    logic [15:0] user_word;
    assign user_word = {user_reg[{user_idx[1:0], 1'b1}], user_reg[{user_idx[1:0], 1'b0}]};

    // ----------------------------------------------------------------------
    // channel outputs
    // ----------------------------------------------------------------------
    logic [13:0] pat_a;
    logic [13:0] pat_b;

    // analog samples ignored whenever a test mode is set
    assign pat_a = pattern(mode_a, i_adc_a.data, pn_long, pn_short, phase, ramp, user_word, user_done); // see R2 see R5
    assign pat_b = pattern(mode_b, i_adc_b.data, pn_long, pn_short, phase, ramp, user_word, user_done);

    // one new word each clock, formatted unless the code bypasses it
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            o_fmt_a <= '0;
            o_fmt_b <= '0;
        end else begin
            o_fmt_a.valid <= (mode_a != TM_NORMAL) || i_adc_a.valid; // see R21
            o_fmt_b.valid <= (mode_b != TM_NORMAL) || i_adc_b.valid;
            o_fmt_a.data  <= bypasses_format(mode_a) ? pat_a : format_word(pat_a, i_twos_comp); // see R3
            o_fmt_b.data  <= bypasses_format(mode_b) ? pat_b : format_word(pat_b, i_twos_comp);
        end
    end

    assign o_test_active = (mode_a != TM_NORMAL) || (mode_b != TM_NORMAL); // see R2

    // ----------------------------------------------------------------------
    // downconverter routing
    // ----------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            for (int k = 0; k < NUM_DDC; k++) o_ddc[k] <= '0;
        end else begin
            for (int k = 0; k < NUM_DDC; k++) begin
                o_ddc[k] <= i_ddc[k];
                if (i_ddc_mode && mode_a != TM_NORMAL && ddc_ctrl[k][`DDC_TEST_I_BIT]) begin
                    o_ddc[k].i_data <= pat_a;       // see R13 see R14 see R15
                end
                if (i_ddc_mode && k != NUM_DDC - 1 && mode_b != TM_NORMAL && ddc_ctrl[k][`DDC_TEST_Q_BIT]) begin
                    o_ddc[k].q_data <= pat_b;       // see R14 see R15
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // link test controls, taken from the registers; a write changes them and soft reset returns them to zero
    // ----------------------------------------------------------------------
    assign o_link_test_mode   = link_mode[3:0];                                      // see R16 see R17
    assign o_link_inject      = inject_point_e'(link_mode[`LINK_INJECT_HI_BIT:`LINK_INJECT_LO_BIT]); // see R20
    assign o_link_sample_test = link_sample[`LINK_SAMPLE_TEST_BIT];                  // see R19

endmodule

// ### design/tpg_pn_gen.sv
// pn sequence generator producing one 14-bit word per clock
`timescale 1ns/1ps
`include "tpg_consts.svh"

module tpg_pn_gen #(
    parameter int        DEG   = 23,
    parameter int        TAP   = 18,
    parameter logic [22:0] SEED = 23'h003AFF,
    parameter int        WIDTH = 14
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    // control
    input  wire logic             i_reseed,
    input  wire logic             i_advance,
    // pattern word
    output logic [WIDTH-1:0]      o_word
);
    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    logic [DEG-1:0] lfsr;
    logic [DEG-1:0] next_lfsr;
    logic [WIDTH-1:0] next_word;

    initial begin
        if (DEG > 23 || TAP >= DEG || WIDTH < 2 || WIDTH > 16) begin
            $error("tpg_pn_gen: bad parameters");
        end
    end

    // step the register WIDTH times, collecting output bits msb first
    always_comb begin
        next_lfsr = lfsr;
        next_word = '0;
        for (int k = 0; k < WIDTH; k++) begin
            next_word = {next_word[WIDTH-2:0], next_lfsr[DEG-1] ^ next_lfsr[TAP-1]};
            next_lfsr = {next_lfsr[DEG-2:0], next_lfsr[DEG-1] ^ next_lfsr[TAP-1]};
        end
    end

    // sequence register, reseeded on demand
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || i_reseed) begin
            lfsr <= SEED[DEG-1:0];
        end else if (i_advance) begin
            lfsr <= next_lfsr;
        end
    end

    // registered word output
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || i_reseed) begin
            o_word <= '0;
        end else if (i_advance) begin
            o_word <= next_word;
        end
    end
endmodule

// ### design/tpg_reg_file.sv
// serial-port register file for the test pattern generator
`timescale 1ns/1ps
`include "tpg_consts.svh"

module tpg_reg_file (
    // clock and reset
    input  wire logic          i_sys_clk,
    input  wire logic          i_reset,
    // register access
    input  wire tpg_pkg::reg_req_s i_req,
    output logic [7:0]         o_rdata,
    // soft reset pulse
    output logic               o_soft_reset,
    // register contents
    output logic [7:0]         o_ctm_a,
    output logic [7:0]         o_ctm_b,
    output logic [7:0]         o_ddc_ctrl [4],
    output logic [7:0]         o_user [8],
    output logic [7:0]         o_link_sample,
    output logic [7:0]         o_link_mode,
    output logic [7:0]         o_link_mode_ext,
    output logic               o_ctm_wr
);
    import tpg_pkg::*;

    // ----------------------------------------------------------------------
    // writes
    // ----------------------------------------------------------------------
    // one-cycle soft reset pulse; the register itself reads zero
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_soft_reset <= 1'b0;
        end else begin
            o_soft_reset <= i_req.wr && i_req.addr == `OFS_CHIP_CONFIG_SOFT_RESET
                            && i_req.wdata == `SOFT_RESET_VALUE; // see R18
        end
    end

    // configuration registers, returned to defaults by soft reset
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || o_soft_reset) begin
            o_ctm_a         <= `REG_RESET_VALUE;
            o_ctm_b         <= `REG_RESET_VALUE;
            o_link_sample   <= `REG_RESET_VALUE;
            o_link_mode     <= `REG_RESET_VALUE;
            o_link_mode_ext <= `REG_RESET_VALUE;
            o_ctm_wr        <= 1'b0;
            for (int k = 0; k < 4; k++) o_ddc_ctrl[k] <= `REG_RESET_VALUE;
            for (int k = 0; k < 8; k++) o_user[k] <= `REG_RESET_VALUE;
        end else begin
            o_ctm_wr <= i_req.wr && i_req.addr == `OFS_CONVERTER_TEST_MODE;
            if (i_req.wr) begin
                case (i_req.addr)
                    `OFS_CONVERTER_TEST_MODE: begin
                        o_ctm_a <= i_req.wdata;
                        o_ctm_b <= i_req.wdata;
                    end
                    `OFS_DDC0_CONTROL:         o_ddc_ctrl[0]   <= i_req.wdata;
                    `OFS_DDC1_CONTROL:         o_ddc_ctrl[1]   <= i_req.wdata;
                    `OFS_DDC2_CONTROL:         o_ddc_ctrl[2]   <= i_req.wdata;
                    `OFS_FOURTH_DOWNCONVERTER_CONTROL:         o_ddc_ctrl[3]   <= i_req.wdata;
                    `OFS_LINK_SAMPLE_TEST_CTRL: o_link_sample  <= i_req.wdata;
                    `OFS_LINK_TEST_MODE:       o_link_mode     <= i_req.wdata;
                    `OFS_LINK_TEST_MODE_EXT:   o_link_mode_ext <= i_req.wdata;
                    default: begin
                        if (i_req.addr >= `OFS_USER_PATTERN_FIRST && i_req.addr <= `OFS_USER_PATTERN_LAST) begin
                            o_user[3'(i_req.addr - `OFS_USER_PATTERN_FIRST)] <= i_req.wdata;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------------
    // reads, registered; unmapped offsets read zero
    // ----------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            case (i_req.addr)
                `OFS_CONVERTER_TEST_MODE:    o_rdata <= o_ctm_a;
                `OFS_DDC0_CONTROL:           o_rdata <= o_ddc_ctrl[0];
                `OFS_DDC1_CONTROL:           o_rdata <= o_ddc_ctrl[1];
                `OFS_DDC2_CONTROL:           o_rdata <= o_ddc_ctrl[2];
                `OFS_FOURTH_DOWNCONVERTER_CONTROL:           o_rdata <= o_ddc_ctrl[3];
                `OFS_LINK_SAMPLE_TEST_CTRL:  o_rdata <= o_link_sample;
                `OFS_LINK_TEST_MODE:         o_rdata <= o_link_mode;
                `OFS_LINK_TEST_MODE_EXT:     o_rdata <= o_link_mode_ext;
                default: begin
                    if (i_req.addr >= `OFS_USER_PATTERN_FIRST && i_req.addr <= `OFS_USER_PATTERN_LAST) begin
                        o_rdata <= o_user[3'(i_req.addr - `OFS_USER_PATTERN_FIRST)];
                    end else begin
                        o_rdata <= 8'h00;
                    end
                end
            endcase
        end
    end
endmodule

// ### inc/tpg_consts.svh
// register offsets, field positions, seeds and pattern words for the test pattern generator
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_CHIP_CONFIG_SOFT_RESET 12'h000
`define OFS_DDC0_CONTROL           12'h327
`define OFS_DDC1_CONTROL           12'h347
`define OFS_DDC2_CONTROL           12'h367
`define OFS_FOURTH_DOWNCONVERTER_CONTROL           12'h387
`define OFS_CONVERTER_TEST_MODE    12'h550
`define OFS_USER_PATTERN_FIRST     12'h551
`define OFS_USER_PATTERN_LAST      12'h558
`define OFS_LINK_SAMPLE_TEST_CTRL  12'h571
`define OFS_LINK_TEST_MODE         12'h573
`define OFS_LINK_TEST_MODE_EXT     12'h574

// ----------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------
`define SOFT_RESET_VALUE       8'h81
`define CTM_PN_RESET_LO_BIT    4
`define CTM_PN_RESET_HI_BIT    5
`define CTM_USER_SINGLE_BIT    7
`define DDC_TEST_I_BIT         0
`define DDC_TEST_Q_BIT         2
`define LINK_SAMPLE_TEST_BIT   5
`define LINK_INJECT_LO_BIT     4
`define LINK_INJECT_HI_BIT     5
`define REG_RESET_VALUE        8'h00

// ----------------------------------------------------------------------
// pattern words and seeds
// ----------------------------------------------------------------------
`define PAT_MIDSCALE           14'h0000
`define PAT_POS_FULL           14'h1FFF
`define PAT_NEG_FULL           14'h2000
`define PAT_CHECKER_A          14'h1555
`define PAT_CHECKER_B          14'h2AAA
`define PAT_ZERO               14'h0000
`define PAT_ONES               14'h3FFF
`define PN23_SEED              23'h003AFF
`define PN9_SEED               9'h092

`endif

// ### inc/tpg_pkg.sv
// types shared by the test pattern generator files
package tpg_pkg;

    // converter test-mode codes
    typedef enum logic [3:0] {
        TM_NORMAL   = 4'h0,
        TM_MIDSCALE = 4'h1,
        TM_POS_FULL = 4'h2,
        TM_NEG_FULL = 4'h3,
        TM_CHECKER  = 4'h4,
        TM_PN_LONG  = 4'h5,
        TM_PN_SHORT = 4'h6,
        TM_TOGGLE   = 4'h7,
        TM_USER     = 4'h8,
        TM_RAMP     = 4'hF
    } test_mode_e;

    // link test injection points
    typedef enum logic [1:0] {
        INJ_SAMPLE   = 2'b00,
        INJ_PHY10    = 2'b01,
        INJ_SCRAMBLE = 2'b10,
        INJ_RESERVED = 2'b11
    } inject_point_e;

    // register access from the serial port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } reg_req_s;

    // one converter sample with its valid flag
    typedef struct packed {
        logic        valid;
        logic [13:0] data;
    } sample_s;

    // downconverter complex output pair
    typedef struct packed {
        logic [13:0] i_data;
        logic [13:0] q_data;
    } iq_s;

endpackage

// ### tb/tb_top.sv
// bench for the converter test pattern generator
`timescale 1ns/1ps
module tb_top;
    import tpg_pkg::*;
    logic i_sys_clk = 1'b0, i_reset = 1'b1, tc = 1'b1, dm = 1'b0, act, lst, srst;
    reg_req_s req = '0;
    sample_s adc = '{1'b1, 14'h0ABC}, fa, fb;
    iq_s din [4] = '{default: '{14'h0123, 14'h0456}}, dout [4];
    logic [7:0] rd_q;
    logic [3:0] lm;
    inject_point_e inj;
    logic [13:0] rxw, pw [3], fx [3] = '{14'h0000, 14'h1FFF, 14'h2000};
    int miscompares = 0, total_checks = 0;
    // 40 MHz encode clock
    always #12.5 i_sys_clk = ~i_sys_clk;
    adc_output_test_pattern_gen adc_output_test_pattern_gen_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_req(req), .o_rdata(rd_q), .i_adc_a(adc), .i_adc_b(adc), .i_twos_comp(tc), .i_ddc(din),
        .i_ddc_mode(dm), .o_fmt_a(fa), .o_fmt_b(fb), .o_ddc(dout), .o_test_active(act),
        .o_link_test_mode(lm), .o_link_inject(inj), .o_link_sample_test(lst), .o_soft_reset(srst));
    tpg_link_rx tpg_link_rx_i (.i_sys_clk(i_sys_clk), .i_lane(fa), .o_word(rxw));
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(posedge i_sys_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge i_sys_clk);
        req <= '0;
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] e);
        @(posedge i_sys_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_sys_clk);
        req <= '0;
        @(posedge i_sys_clk);
        #1 chk("rdata", {8'h00, rd_q}, {8'h00, e});
    endtask
    task automatic smp(logic [13:0] e);
        @(posedge i_sys_clk);
        #1 chk("fmt_a", {2'h0, fa.data}, {2'h0, e});
        chk("fmt_b", {2'h0, fb.data}, {2'h0, e});
    endtask
    // mode write plus settle cycle
    task automatic mode(logic [7:0] m);
        wr(12'h550, m);
        @(posedge i_sys_clk);
    endtask
    function automatic logic [15:0] up(int k);
        return {8'((2 * k + 2) * 55), 8'((2 * k + 1) * 55)};
    endfunction
    task automatic stop_test;
        $display("total_checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rd(12'h550, 8'h00);
        rd(12'h123, 8'h00);
        for (int k = 0; k < 6; k++) begin
            wr(12'h550, 8'(k / 2 + 1));
            tc <= k[0];
            @(posedge i_sys_clk);
            smp(fx[k / 2] ^ {~k[0], 13'h0});
        end
        chk("active", {15'h0, act}, 16'h1);
        mode(8'h04);
        smp(14'h1555);
        smp(14'h2AAA);
        rd(12'h550, 8'h04);
        mode(8'h07);
        smp(14'h0000);
        smp(14'h3FFF);
        mode(8'h0F);
        smp(14'h0000);
        smp(14'h0001);
        foreach (fx[c]) begin
            for (int r = 0; r < 2; r++) begin
                mode(c == 0 ? 8'h15 : 8'h26);
                @(posedge i_sys_clk);
                for (int j = 0; j < 3; j++) begin
                    @(posedge i_sys_clk);
                    #1 if (r == 0) pw[j] = rxw;
                    else chk("pn seed", {2'h0, rxw}, {2'h0, pw[j]});
                end
            end
            chk("pn step", {15'h0, pw[1] == pw[2]}, 16'h0);
        end
        for (int i = 0; i < 8; i++) wr(12'(12'h551 + i), 8'((i + 1) * 55));
        for (int s = 0; s < 2; s++) begin
            mode({s[0], 7'h08});
            for (int j = 0; j < 6; j++) smp(j < 4 ? up(j) >> 2 : (s ? 14'h0 : up(j - 4) >> 2));
        end
        dm <= 1'b1;
        wr(12'h327, 8'h05);
        wr(12'h387, 8'h01);
        mode(8'h07);
        @(posedge i_sys_clk);
        #1 chk("ddc0 q", {2'h0, dout[0].q_data}, {2'h0, dout[0].i_data});
        chk("fourth_downconverter i", {2'h0, dout[3].i_data}, {2'h0, fa.data});
        chk("fourth_downconverter q", {2'h0, dout[3].q_data}, 16'h0456);
        chk("ddc1 i", {2'h0, dout[1].i_data}, 16'h0123);
        wr(12'h573, 8'h21);
        wr(12'h571, 8'h20);
        @(posedge i_sys_clk);
        #1 chk("link", {10'h0, lst, inj, lm[0]}, 16'h000D);
        wr(12'h000, 8'h80);
        wr(12'h000, 8'h81);
        repeat (2) @(posedge i_sys_clk);
        #1 chk("cleared", {12'h0, act, lst, lm[1:0]}, 16'h0);
        rd(12'h000, 8'h00);
        stop_test;
    end
endmodule
bind adc_output_test_pattern_gen tpg_props tpg_props_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(i_req),
    .i_twos_comp(i_twos_comp), .o_fmt_a(o_fmt_a), .o_link_test_mode(o_link_test_mode),
    .o_link_inject(o_link_inject), .o_link_sample_test(o_link_sample_test), .o_soft_reset(o_soft_reset));

// ### tb/tpg_link_rx.sv
// far-side receiver model taking one word per encode clock
`timescale 1ns/1ps
module tpg_link_rx (
    // clock and lane
    input  wire logic             i_sys_clk,
    input  wire tpg_pkg::sample_s i_lane,
    // captured word
    output logic [13:0]           o_word
);
    import tpg_pkg::*;
    // capture valid words, invert the held word when idle
    always_ff @(posedge i_sys_clk) begin
        o_word <= i_lane.valid ? i_lane.data : ~o_word;
    end
endmodule

// ### tb/tpg_props.sv
// port assertions for the pattern generator
`timescale 1ns/1ps
module tpg_props (
    // clock, reset, access
    input wire logic                   i_sys_clk,
    input wire logic                   i_reset,
    input wire tpg_pkg::reg_req_s      i_req,
    input wire logic                   i_twos_comp,
    // outputs watched
    input wire tpg_pkg::sample_s       o_fmt_a,
    input wire logic [3:0]             o_link_test_mode,
    input wire tpg_pkg::inject_point_e o_link_inject,
    input wire logic                   o_link_sample_test,
    input wire logic                   o_soft_reset
);
    import tpg_pkg::*;
    logic [3:0] mode;
    logic [1:0] age;
    wire        st = age == 2'h3 && !o_soft_reset;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // last mode written and cycles since
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || o_soft_reset) begin
            mode <= 4'h0;
            age  <= 2'h0;
        end else if (i_req.wr && i_req.addr == 12'h550) begin
            mode <= i_req.wdata[3:0];
            age  <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    sequence s_srst; i_req.wr && i_req.addr == 12'h000 && i_req.wdata == 8'h81; endsequence
    sequence s_pulse; o_soft_reset ##1 !o_soft_reset; endsequence
    property p_srst; s_srst |=> s_pulse; endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
    property p_chk; st && mode == 4'h4 && o_fmt_a.data == 14'h1555 |=> o_fmt_a.data == 14'h2AAA; endproperty
    a_chk: assert property (p_chk) else $error("checkerboard wrong");
    property p_tgl; st && mode == 4'h7 |=> (o_fmt_a.data ^ $past(o_fmt_a.data)) == 14'h3FFF; endproperty
    a_tgl: assert property (p_tgl) else $error("toggle wrong");
    property p_ramp; st && mode == 4'hF && $stable(i_twos_comp) |=> o_fmt_a.data == $past(o_fmt_a.data) + 14'h1;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step wrong");
    property p_full; st && mode == 4'h2 && $stable(i_twos_comp) |-> o_fmt_a.data == {~i_twos_comp, 13'h1FFF};
    endproperty
    a_full: assert property (p_full) else $error("full scale wrong");
    property p_link; i_req.wr && i_req.addr == 12'h573 && o_link_test_mode == 4'h0 |=>
        o_link_test_mode == $past(i_req.wdata[3:0]) && o_link_inject == $past(i_req.wdata[5:4]); endproperty
    a_link: assert property (p_link) else $error("link mode wrong");
    property p_stest; i_req.wr && i_req.addr == 12'h571 |=> o_link_sample_test == $past(i_req.wdata[5]); endproperty
    a_stest: assert property (p_stest) else $error("sample test wrong");
    property p_sclr; o_soft_reset |=> o_link_test_mode == 4'h0 && !o_link_sample_test; endproperty
    a_sclr: assert property (p_sclr) else $error("soft reset no clear");
endmodule
